// ---- core/spb_pkg.sv ----
// Purpose: constants for the spi pin control and bit-rate block
// Assumes: ahb-lite register access, 32-bit words, byte-wide registers
// Notes: offsets chosen for this block; upper bits read as zero
package spb_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] PIN_CTRL_ADDR = 12'h000;
    localparam logic [11:0] BIT_RATE_ADDR = 12'h004;
    localparam logic [11:0] MODE_ADDR = 12'h008;
    localparam logic [11:0] STATUS_ADDR = 12'h00C;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int MODE_FAULT_EN_BIT = 4;
    localparam int BIDIR_OE_BIT = 3;
    localparam int STOP_WAIT_BIT = 1;
    localparam int SINGLE_WIRE_BIT = 0;
    localparam logic [7:0] PIN_CTRL_MASK = 8'h1B;
    localparam logic [7:0] BIT_RATE_MASK = 8'h7F;
    localparam int PRESCALE_LSB = 4;
    localparam int RATE_LSB = 0;
    localparam logic [3:0] RATE_MAX_CODE = 4'h8;
    localparam int MASTER_BIT = 0;
    localparam int WAIT_BIT = 1;
    // ------------------------------------------------------------
    // reset values and bus encodings
    // ------------------------------------------------------------
    localparam logic [7:0] PIN_CTRL_RESET = 8'h00;
    localparam logic [7:0] BIT_RATE_RESET = 8'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : spb_pkg

// ---- core/spb_pin_baud.sv ----
// Purpose: select pin routing, shared data pin routing, bit-rate clock
// Assumes: single ahb-lite slave, zero wait states
// Notes: bit clock toggles every half rate period while enabled in master mode, held low in slave mode
`timescale 1ns/100ps
module spb_pin_baud (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic selectPinIn,
    output logic selectPinOut,
    output logic selectPinOe,
    output logic selectDriveLevelOut,
    input wire logic selectOutLevel,
    input wire logic masterOutPinIn,
    output logic masterOutPinOut,
    output logic masterOutPinOe,
    input wire logic slaveOutPinIn,
    output logic slaveOutPinOut,
    output logic slaveOutPinOe,
    input wire logic serialDataOut,
    output logic serialDataIn,
    output logic modeFaultInput,
    output logic slaveSelectN,
    output logic bitClock,
    output logic bitClockTick,
    output logic spiClockEnable
);
    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic [7:0] pinCtrl_reg;
    logic [7:0] bitRate_reg;
    logic [1:0] mode_reg;
    logic wrPend_reg;
    logic [11:0] wrAddr_reg;
    logic addrPhase;
    assign addrPhase = hsel && hready && htrans == spb_pkg::HTRANS_NONSEQ;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 12'h000;
        end else begin
            wrPend_reg <= addrPhase && hwrite;
            if (addrPhase)
                wrAddr_reg <= haddr[11:0];
        end
    end

    // writes to the rate register are accepted in every mode
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pinCtrl_reg <= spb_pkg::PIN_CTRL_RESET;
            bitRate_reg <= spb_pkg::BIT_RATE_RESET;
            mode_reg <= 2'h0;
        end else if (wrPend_reg) begin
            case (wrAddr_reg)
                spb_pkg::PIN_CTRL_ADDR:
                    pinCtrl_reg <= hwdata[7:0] & spb_pkg::PIN_CTRL_MASK;
                spb_pkg::BIT_RATE_ADDR:
                    bitRate_reg <= hwdata[7:0] & spb_pkg::BIT_RATE_MASK;
                spb_pkg::MODE_ADDR:
                    mode_reg <= hwdata[1:0];
                default: ;
            endcase
        end
    end

    logic sel1_reg, sel2_reg, mo1_reg, mo2_reg, so1_reg, so2_reg;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            {sel1_reg, sel2_reg} <= 2'h3;
            {mo1_reg, mo2_reg, so1_reg, so2_reg} <= 4'h0;
        end else begin
            sel1_reg <= selectPinIn;
            sel2_reg <= sel1_reg;
            mo1_reg <= masterOutPinIn;
            mo2_reg <= mo1_reg;
            so1_reg <= slaveOutPinIn;
            so2_reg <= so1_reg;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hrdata <= 32'h0000_0000;
        end else if (addrPhase && !hwrite) begin
            case (haddr[11:0])
                spb_pkg::PIN_CTRL_ADDR: hrdata <= {24'h000000, pinCtrl_reg};
                spb_pkg::BIT_RATE_ADDR: hrdata <= {24'h000000, bitRate_reg};
                spb_pkg::MODE_ADDR: hrdata <= {30'h0, mode_reg};
                spb_pkg::STATUS_ADDR:
                    hrdata <= {29'h0, bitClock, modeFaultInput, slaveSelectN};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    logic isMaster, faultEn, selOe, singleWire, bidir_output_enable, waitMode;
    assign isMaster = mode_reg[spb_pkg::MASTER_BIT];
    assign waitMode = mode_reg[spb_pkg::WAIT_BIT];
    assign faultEn = pinCtrl_reg[spb_pkg::MODE_FAULT_EN_BIT];
    assign bidir_output_enable = pinCtrl_reg[spb_pkg::BIDIR_OE_BIT];
    assign singleWire = pinCtrl_reg[spb_pkg::SINGLE_WIRE_BIT];
    assign selOe = selectOutLevel;

    // ------------------------------------------------------------
    // select pin
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            selectPinOe <= 1'b0;
            selectPinOut <= 1'b1;
            modeFaultInput <= 1'b0;
            slaveSelectN <= 1'b1;
            selectDriveLevelOut <= 1'b0;
        end else begin
            selectDriveLevelOut <= isMaster && faultEn && selOe;
            if (!isMaster) begin
                selectPinOe <= 1'b0;
                slaveSelectN <= sel2_reg;
                modeFaultInput <= 1'b0;
            end else if (!faultEn) begin
                selectPinOe <= 1'b0;
                slaveSelectN <= 1'b1;
                modeFaultInput <= 1'b0;
            end else if (!selOe) begin
                selectPinOe <= 1'b0;
                slaveSelectN <= 1'b1;
                modeFaultInput <= !sel2_reg;
            end else begin
                selectPinOe <= 1'b1;
                selectPinOut <= 1'b0;
                slaveSelectN <= 1'b1;
                modeFaultInput <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // data pins
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            masterOutPinOe <= 1'b0;
            slaveOutPinOe <= 1'b0;
            masterOutPinOut <= 1'b0;
            slaveOutPinOut <= 1'b0;
            serialDataIn <= 1'b0;
        end else begin
            masterOutPinOut <= serialDataOut;
            slaveOutPinOut <= serialDataOut;
            if (!singleWire) begin
                masterOutPinOe <= isMaster;
                slaveOutPinOe <= !isMaster;
                serialDataIn <= isMaster ? so2_reg : mo2_reg;
            end else if (isMaster) begin
                masterOutPinOe <= bidir_output_enable;
                slaveOutPinOe <= 1'b0;
                serialDataIn <= mo2_reg;
            end else begin
                masterOutPinOe <= 1'b0;
                slaveOutPinOe <= bidir_output_enable;
                serialDataIn <= so2_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // bit-rate generator
    // ------------------------------------------------------------
    logic clkRun;
    assign clkRun = !(waitMode && pinCtrl_reg[spb_pkg::STOP_WAIT_BIT]);
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            spiClockEnable <= 1'b1;
        else
            spiClockEnable <= clkRun;
    end

    logic [2:0] preCode;
    logic [3:0] rateCode;
    logic [2:0] pre_reg;
    logic [8:0] rate_reg;
    logic [8:0] halfLimit;
    logic preTick;
    assign preCode = bitRate_reg[spb_pkg::PRESCALE_LSB +: 3];
    assign rateCode = bitRate_reg[spb_pkg::RATE_LSB +: 4];
    assign preTick = pre_reg >= preCode;
    // half period in prescaled ticks: 2^code, capped at 256
    assign halfLimit = (rateCode > spb_pkg::RATE_MAX_CODE) ?
        9'h100 : 9'(9'h001 << rateCode);

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn)
            pre_reg <= 3'h0;
        else if (!clkRun || preTick)
            pre_reg <= 3'h0;
        else
            pre_reg <= pre_reg + 3'h1;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rate_reg <= 9'h000;
            bitClock <= 1'b0;
            bitClockTick <= 1'b0;
        end else begin
            bitClockTick <= 1'b0;
            if (!clkRun || !isMaster) begin
                rate_reg <= 9'h000;
                bitClock <= 1'b0;
            end else if (preTick) begin
                if (rate_reg + 9'h001 >= halfLimit) begin
                    rate_reg <= 9'h000;
                    bitClock <= !bitClock;
                    bitClockTick <= 1'b1;
                end else begin
                    rate_reg <= rate_reg + 9'h001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_slave_sel_in: assert property (@(posedge ref_clk) disable iff (!rstn)
        !isMaster |=> !selectPinOe)
        else $error("select pin driven in slave mode");
    chk_gpio_release: assert property (@(posedge ref_clk) disable iff (!rstn)
        isMaster && !faultEn |=> !selectPinOe && !modeFaultInput)
        else $error("select pin used with fault enable clear");
    chk_fault_input: assert property (@(posedge ref_clk) disable iff (!rstn)
        isMaster && faultEn && !selOe && !sel2_reg |=> modeFaultInput)
        else $error("mode fault input missed");
    chk_sel_output: assert property (@(posedge ref_clk) disable iff (!rstn)
        isMaster && faultEn && selOe |=> selectPinOe)
        else $error("select output not driven");
    chk_bidir_drive: assert property (@(posedge ref_clk) disable iff (!rstn)
        singleWire && isMaster |=> masterOutPinOe == $past(bidir_output_enable))
        else $error("shared pin driver wrong");
    chk_two_wire: assert property (@(posedge ref_clk) disable iff (!rstn)
        !singleWire && isMaster |=> masterOutPinOe && !slaveOutPinOe)
        else $error("two wire pin drivers wrong");
    chk_slave_share: assert property (@(posedge ref_clk) disable iff (!rstn)
        singleWire && !isMaster |=> !masterOutPinOe)
        else $error("master pin driven in slave single wire");
    chk_wait_gate: assert property (@(posedge ref_clk) disable iff (!rstn)
        !clkRun |=> !spiClockEnable && !bitClockTick && !bitClock)
        else $error("clocks run in gated wait");
    chk_fast_rate: assert property (@(posedge ref_clk) disable iff (!rstn)
        bitClockTick && bitRate_reg == 8'h00 && isMaster && clkRun
        && $stable(bitRate_reg) |=> bitClockTick)
        else $error("fastest rate misses a toggle");
    chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
        (pinCtrl_reg & ~spb_pkg::PIN_CTRL_MASK) == 8'h00)
        else $error("reserved control bits set");
    cov_master_tick: cover property (@(posedge ref_clk) disable iff (!rstn)
        isMaster && bitClockTick);
    cov_fault: cover property (@(posedge ref_clk) disable iff (!rstn)
        modeFaultInput);
    cov_bidir_slave: cover property (@(posedge ref_clk) disable iff (!rstn)
        slaveOutPinOe && singleWire);
    cov_wait_gated: cover property (@(posedge ref_clk) disable iff (!rstn)
        !spiClockEnable);
    chk_pre_bound: assert property (@(posedge ref_clk) disable iff (!rstn)
        $stable(bitRate_reg) |-> pre_reg <= preCode)
        else $error("prescale count beyond divisor");
    chk_slave_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
        !isMaster |=> !bitClock && !bitClockTick)
        else $error("bit clock runs in slave mode");
    chk_toggle_tick: assert property (@(posedge ref_clk) disable iff (!rstn)
        bitClockTick |-> bitClock != $past(bitClock))
        else $error("tick without bit clock toggle");
    chk_master_din: assert property (@(posedge ref_clk) disable iff (!rstn)
        !singleWire && isMaster
        |=> serialDataIn == $past(so2_reg))
        else $error("master data input pin wrong");
    chk_slave_din: assert property (@(posedge ref_clk) disable iff (!rstn)
        singleWire && !isMaster
        |=> serialDataIn == $past(so2_reg))
        else $error("slave shared pin input wrong");
endmodule : spb_pin_baud

// ---- verif/spb_peer.sv ----
// Purpose: external spi peer seen from the select and data pins
// Assumes: the peer drives a line only while the block does not
// Notes: the two data pins carry opposite peer levels
`timescale 1ns/100ps
module spb_peer (
    input wire logic peerSelN,
    input wire logic peerData,
    input wire logic selOut,
    input wire logic selOe,
    input wire logic moOut,
    input wire logic moOe,
    input wire logic soOut,
    input wire logic soOe,
    output logic selWire,
    output logic moWire,
    output logic soWire
);
    // --------------------------------------------------------
    // wire resolution
    // --------------------------------------------------------
    assign selWire = selOe ? selOut : peerSelN;
    assign moWire = moOe ? moOut : peerData;
    assign soWire = soOe ? soOut : ~peerData;
endmodule : spb_peer

// ---- verif/spi_pin_config_baud_gen_tb.sv ----
// Purpose: self-checking bench for pin routing and bit-rate clock
// Assumes: zero wait state slave, pins settle within six cycles
// Notes: read results are queued and checked by a monitor
`timescale 1ns/100ps
module spi_pin_config_baud_gen_tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic hreadyout, hresp, selOut, selOe, selDrive, moOut, moOe;
    logic soOut, soOe, selWire, moWire, soWire, sdi, mfIn, ssN;
    logic bclk, tick, clkEn, b;
    logic rdPend = 1'b0;
    logic selLevel = 1'b0;
    logic sdo = 1'b0;
    logic peerSelN = 1'b1;
    logic peerData = 1'b0;
    logic [31:0] expQ [$];
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    int seed = 32'hE5D82B25;
    int n, p, r;
    initial forever #2 ref_clk = ~ref_clk;
    spb_pin_baud u_spb_pin_baud (.ref_clk(ref_clk), .rstn(rstn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(spb_pkg::HSIZE_WORD), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .selectPinIn(selWire), .selectPinOut(selOut), .selectPinOe(selOe),
        .selectDriveLevelOut(selDrive), .selectOutLevel(selLevel),
        .masterOutPinIn(moWire), .masterOutPinOut(moOut),
        .masterOutPinOe(moOe), .slaveOutPinIn(soWire),
        .slaveOutPinOut(soOut), .slaveOutPinOe(soOe),
        .serialDataOut(sdo), .serialDataIn(sdi), .modeFaultInput(mfIn),
        .slaveSelectN(ssN), .bitClock(bclk), .bitClockTick(tick),
        .spiClockEnable(clkEn));
    spb_peer u_spb_peer (.peerSelN(peerSelN), .peerData(peerData),
        .selOut(selOut), .selOe(selOe), .moOut(moOut), .moOe(moOe),
        .soOut(soOut), .soOe(soOe), .selWire(selWire), .moWire(moWire),
        .soWire(soWire));
    // --------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic bus(input logic [11:0] a, input logic wr,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= spb_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge ref_clk);
        while (!hreadyout) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge ref_clk);
        while (!hreadyout) @(posedge ref_clk);
    endtask : bus
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expQ.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask : rd
    task automatic gap(output int k);
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (!tick && k < 3000);
    endtask : gap
    // --------------------------------------------------------
    // read monitor and timeout
    // --------------------------------------------------------
    always @(posedge ref_clk) begin
        if (rdPend && hreadyout) begin
            check("hrdata", hrdata, expQ.pop_front());
            check("hresp", hresp, 32'h0);
            rdPend = 1'b0;
        end
        if (hsel && htrans == spb_pkg::HTRANS_NONSEQ && !hwrite && hreadyout)
            rdPend = 1'b1;
        cyc++;
        if (cyc == 80000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        rd(spb_pkg::PIN_CTRL_ADDR, 32'h0);
        rd(spb_pkg::BIT_RATE_ADDR, 32'h0);
        bus(spb_pkg::PIN_CTRL_ADDR, 1'b1, 32'hFFFFFFFF);
        rd(spb_pkg::PIN_CTRL_ADDR, 32'h1B);
        n = $random(seed);
        bus(spb_pkg::BIT_RATE_ADDR, 1'b1, n);
        rd(spb_pkg::BIT_RATE_ADDR, n & 32'h7F);
        bus(12'h010, 1'b1, 32'hFF);
        rd(12'h010, 32'h0);
        $display("register test done");
        for (int i = 0; i < 32; i++) begin
            bus(spb_pkg::MODE_ADDR, 1'b1, {31'h0, i[0]});
            bus(spb_pkg::PIN_CTRL_ADDR, 1'b1, {27'h0, i[1], 4'h0});
            selLevel <= i[2];
            peerSelN <= i[3];
            repeat (6) @(posedge ref_clk);
            p = i[0] & i[1] & i[2];
            check("selOe", selOe, p);
            check("selDrive", selDrive, p);
            if (p) check("selWire", selWire, 32'h0);
            check("fault", mfIn, i[0] & i[1] & !i[2] & !i[3]);
            if (!i[0]) check("ssN", ssN, i[3]);
        end
        $display("select pin test done");
        peerSelN <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            bus(spb_pkg::MODE_ADDR, 1'b1, {31'h0, i[0]});
            bus(spb_pkg::PIN_CTRL_ADDR, 1'b1, {28'h0, i[2], 2'h0, i[1]});
            sdo <= i[3];
            b = 1'($random(seed));
            peerData <= b;
            repeat (6) @(posedge ref_clk);
            p = !i[1] | i[2];
            check("moOe", moOe, i[0] & p);
            check("soOe", soOe, !i[0] & p);
            if (moOe) check("moWire", moWire, i[3]);
            if (soOe) check("soWire", soWire, i[3]);
            if (!(i[1] & i[2]))
                check("sdi", sdi, (i[0] != i[1]) ? !b : b);
        end
        $display("data pin test done");
        bus(spb_pkg::MODE_ADDR, 1'b1, 32'h1);
        for (int i = 0; i < 20; i++) begin
            p = (i < 8) ? i : (i < 16) ? 0 : ($random(seed) & 7);
            r = (i < 8) ? 0 : (i < 17) ? i - 8 :
                (i == 17) ? 15 : ($random(seed) & 15);
            bus(spb_pkg::BIT_RATE_ADDR, 1'b1, (p << 4) | r);
            // rate codes above eight act as code eight, a half period of 256 prescaled ticks
            if (r > 8)
                r = 8;
            repeat (2) gap(n);
            b = bclk;
            gap(n);
            check("period", n, (p + 1) << r);
            check("bclk", bclk, !b);
        end
        $display("bit rate test done");
        bus(spb_pkg::MODE_ADDR, 1'b1, 32'h0);
        @(posedge ref_clk);
        gap(n);
        check("slaveTicks", n, 3000);
        bus(spb_pkg::PIN_CTRL_ADDR, 1'b1, 32'h2);
        bus(spb_pkg::MODE_ADDR, 1'b1, 32'h3);
        gap(n);
        check("gated", clkEn, 32'h0);
        check("waitTicks", n, 3000);
        bus(spb_pkg::PIN_CTRL_ADDR, 1'b1, 32'h0);
        gap(n);
        gap(n);
        check("running", clkEn, 32'h1);
        check("waitRun", n < 3000, 32'h1);
        $display("wait mode test done");
        report_and_stop();
    end
endmodule : spi_pin_config_baud_gen_tb
